/* tcs_pkg.sv */
// package: register map, field layout and codes of the connection status block
package tcs_pkg;
  // ----------------------------------------
  // register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] OFS_CONN_STATUS = 8'h08;
  localparam logic [7:0] OFS_CSR = 8'h09;
  localparam logic [7:0] OFS_GEN_CTRL = 8'h0A;
  localparam logic [7:0] CSR_RST = 8'h20;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] RD_ZERO = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CS_ACC_HI = 3;
  localparam int CS_ACC_LO = 1;
  localparam int CS_CABLE = 0;
  localparam int CSR_ATT_HI = 7;
  localparam int CSR_ATT_LO = 6;
  localparam int CSR_DIR = 5;
  localparam int CSR_INT = 4;
  localparam int CSR_FLT = 3;
  localparam int CSR_DUTY_HI = 2;
  localparam int CSR_DUTY_LO = 1;
  localparam int CSR_SNK_ACC = 0;
  localparam int GEN_SRST = 3;
  // ----------------------------------------
  // field codes and resets
  // ----------------------------------------
  localparam logic [2:0] ACC_NONE = 3'h0;
  localparam logic [2:0] ACC_AUDIO = 3'h4;
  localparam logic [2:0] ACC_AUDIO_CT = 3'h5;
  localparam logic [2:0] ACC_DBG_SRC = 3'h6;
  localparam logic [2:0] ACC_DBG_SNK = 3'h7;
  localparam logic [1:0] ATT_NONE = 2'h0;
  localparam logic [1:0] DUTY_RST = 2'h0;
  localparam logic DIR_RST = 1'b1;
  localparam logic [6:0] I2C_ADDR_DFLT = 7'h47;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} tcs_state_t;
  typedef enum logic [1:0] {K_ADDR, K_SUB, K_DATA} tcs_kind_t;
endpackage : tcs_pkg

/* tcs_reg_if.sv */
// interface: byte access path from the serial target to the register bank
`timescale 1ns/10ps
interface tcs_reg_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output wr_stb, output addr, output wdata, input rdata);
  modport target (input wr_stb, input addr, input wdata, output rdata);
endinterface : tcs_reg_if

/* tcs_i2c_target.sv */
// module: serial two-wire target engine with auto-incrementing byte pointer
`timescale 1ns/10ps
module tcs_i2c_target #(
  parameter logic [6:0] DEV_ADDR = tcs_pkg::I2C_ADDR_DFLT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_s,
  input wire logic scl_d,
  input wire logic sda_s,
  input wire logic sda_d,
  output logic sda_oe,
  tcs_reg_if.master bus
);
  tcs_pkg::tcs_state_t st_r, st_nxt;
  tcs_pkg::tcs_kind_t kind_r, kind_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt;
  logic oe_r, oe_nxt;
  logic wr_r, wr_nxt;
  logic rise, fall, start, stop;

  assign rise = scl_s & ~scl_d;
  assign fall = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_oe = oe_r;
  assign bus.wr_stb = wr_r;
  assign bus.addr = ptr_r;
  assign bus.wdata = sh_r;

  // ----------------------------------------
  // byte sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    wr_nxt = 1'b0;
    if (start) begin
      st_nxt = tcs_pkg::ST_RX;
      kind_nxt = tcs_pkg::K_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (stop) begin
      st_nxt = tcs_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        tcs_pkg::ST_RX: begin
          if (rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          if (fall && cnt_r == tcs_pkg::BITS_PER_BYTE) begin
            st_nxt = tcs_pkg::ST_ACK;
            oe_nxt = 1'b1;
            if (kind_r == tcs_pkg::K_ADDR) begin
              rw_nxt = sh_r[0];
              if (sh_r[7:1] != DEV_ADDR) begin
                st_nxt = tcs_pkg::ST_IDLE;
                oe_nxt = 1'b0;
              end
            end else if (kind_r == tcs_pkg::K_SUB) begin
              ptr_nxt = sh_r; // see R12
            end else begin
              wr_nxt = 1'b1;
            end
          end
        end
        tcs_pkg::ST_ACK: begin
          if (fall) begin
            cnt_nxt = 4'h0;
            if (kind_r == tcs_pkg::K_ADDR && rw_r) begin
              st_nxt = tcs_pkg::ST_TX;
              sh_nxt = bus.rdata; // see R12
              oe_nxt = ~bus.rdata[7];
            end else begin
              st_nxt = tcs_pkg::ST_RX;
              oe_nxt = 1'b0;
              if (kind_r == tcs_pkg::K_DATA) begin
                ptr_nxt = ptr_r + 8'h01;
              end
            end
            kind_nxt = (kind_r == tcs_pkg::K_ADDR && !rw_r) ? tcs_pkg::K_SUB : tcs_pkg::K_DATA;
          end
        end
        tcs_pkg::ST_TX: begin
          if (fall) begin
            if (cnt_r == 4'h7) begin
              st_nxt = tcs_pkg::ST_RACK;
              oe_nxt = 1'b0;
              ptr_nxt = ptr_r + 8'h01; // see R12
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
              oe_nxt = ~sh_r[6];
            end
          end
        end
        tcs_pkg::ST_RACK: begin
          if (rise && sda_s) begin
            st_nxt = tcs_pkg::ST_IDLE;
          end else if (fall) begin
            st_nxt = tcs_pkg::ST_TX;
            sh_nxt = bus.rdata;
            oe_nxt = ~bus.rdata[7];
            cnt_nxt = 4'h0;
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= tcs_pkg::ST_IDLE;
      kind_r <= tcs_pkg::K_ADDR;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= tcs_pkg::PTR_RST;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
      wr_r <= wr_nxt;
    end
  end

  a_ptr_after_read: assert property (@(posedge clk) disable iff (!nrst) // see R12
    (st_r == tcs_pkg::ST_TX && fall && cnt_r == 4'h7 && !start && !stop)
      |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not advance after a read byte");
  a_ack_held: assert property (@(posedge clk) disable iff (!nrst) // see R12
    (st_r == tcs_pkg::ST_ACK) |-> oe_r)
    else $error("acknowledge slot not driven low");
endmodule : tcs_i2c_target

/* tcs_conn_status_csr.sv */
// module: connection status and control registers behind a two-wire target port
//
// Functional notes
// R1: bits 3..1 of connection status give the accessory: 000 none, 100 audio, 101 audio charge-through, 110 debug as source, 111 debug as sink, 001..011 reserved.
// R2: bit 0 of connection status resets to 0 and shows an active cable is plugged in.
// R3: bits 7..6 of the control/status register give attach: 00 none, 01 source, 10 sink, 11 accessory.
// R4: bit 5 gives cable orientation, 0 first channel pin, 1 second, reset value 1.
// R5: the active-low interrupt pin goes low whenever a register value changes.
// R6: bit 4 is set on any register change, reads 1 only while the pin is low, and holds until the host clears it; it reads 0 while bit 3 alone holds the pin
// R7: bit 3 resets to 0 and is set with the interrupt pin on a cable power overcurrent trip, cleared by the host.
// R8: bits 2..1 are host-writable and pick the source share of the toggle period, 30/40/50/60 percent, reset 00.
// R9: bit 0 is host-writable, resets to 0, and when 1 stops accessory recognition as sink.
// R10: the control/status register lives at 0x09 and resets to 0x20.
// R11: writing 1 to the self-clearing soft reset bit resets the status fields of the logic.
// R12: reads start at 00h, at the last read plus one, or at a written sub-address, then step by one byte.
// R13: the interrupt pin returns high once both flags are cleared and no change is pending.
`timescale 1ns/10ps
module tcs_conn_status_csr #(
  parameter logic [6:0] DEV_ADDR = tcs_pkg::I2C_ADDR_DFLT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] accessory_in,
  input wire logic active_cable_in,
  input wire logic [1:0] attach_in,
  input wire logic orient_in,
  input wire logic cable_power_overcurrent,
  output logic int_n,
  output logic [1:0] toggle_source_share,
  output logic sink_accessory_off,
  output logic soft_reset_out
);
  tcs_reg_if bus ();

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] scl_sy_r, scl_sy_nxt;
  logic [2:0] sda_sy_r, sda_sy_nxt;
  logic sda_oe_int;
  logic oe_r, oe_nxt;

  always_comb begin
    scl_sy_nxt = {scl_sy_r[1:0], scl_i};
    sda_sy_nxt = {sda_sy_r[1:0], sda_i};
    oe_nxt = sda_oe_int;
  end

  // idle bus is high, so sync stages reset high to avoid a false start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      oe_r <= 1'b0;
    end else begin
      scl_sy_r <= scl_sy_nxt;
      sda_sy_r <= sda_sy_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_r;

  tcs_i2c_target #(.DEV_ADDR(DEV_ADDR)) u_target (
    .clk(clk),
    .nrst(nrst),
    .scl_s(scl_sy_r[1]),
    .scl_d(scl_sy_r[2]),
    .sda_s(sda_sy_r[1]),
    .sda_d(sda_sy_r[2]),
    .sda_oe(sda_oe_int),
    .bus(bus.master)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [2:0] acc_r, acc_nxt;
  logic cable_r, cable_nxt;
  logic [1:0] att_r, att_nxt;
  logic dir_r, dir_nxt;
  logic int_r, int_nxt;
  logic flt_r, flt_nxt;
  logic [1:0] duty_r, duty_nxt;
  logic snk_r, snk_nxt;
  logic srst_r, srst_nxt;
  logic int_n_r, int_n_nxt;
  logic wr_csr, wr_gen, chg;
  logic [2:0] acc_eff;

  assign wr_csr = bus.wr_stb && bus.addr == tcs_pkg::OFS_CSR;
  assign wr_gen = bus.wr_stb && bus.addr == tcs_pkg::OFS_GEN_CTRL;

  always_comb begin
    acc_eff = accessory_in;
    if (accessory_in != tcs_pkg::ACC_AUDIO && accessory_in != tcs_pkg::ACC_AUDIO_CT
        && accessory_in != tcs_pkg::ACC_DBG_SRC && accessory_in != tcs_pkg::ACC_DBG_SNK) begin
      acc_eff = tcs_pkg::ACC_NONE; // see R1
    end else if (snk_r && accessory_in == tcs_pkg::ACC_DBG_SNK) begin
      acc_eff = tcs_pkg::ACC_NONE; // see R9
    end
    duty_nxt = duty_r;
    snk_nxt = snk_r;
    if (wr_csr) begin
      duty_nxt = bus.wdata[tcs_pkg::CSR_DUTY_HI:tcs_pkg::CSR_DUTY_LO]; // see R8
      snk_nxt = bus.wdata[tcs_pkg::CSR_SNK_ACC]; // see R9
    end
    srst_nxt = wr_gen && bus.wdata[tcs_pkg::GEN_SRST]; // see R11
    if (srst_r) begin
      acc_nxt = tcs_pkg::ACC_NONE; // see R11
      cable_nxt = 1'b0;
      att_nxt = tcs_pkg::ATT_NONE;
      dir_nxt = tcs_pkg::DIR_RST;
    end else begin
      acc_nxt = acc_eff; // see R1
      cable_nxt = active_cable_in; // see R2
      att_nxt = attach_in; // see R3
      dir_nxt = orient_in; // see R4
    end
    chg = {acc_nxt, cable_nxt, att_nxt, dir_nxt, duty_nxt, snk_nxt}
      != {acc_r, cable_r, att_r, dir_r, duty_r, snk_r} || cable_power_overcurrent;
    // set beats a simultaneous host clear so no event is lost
    int_nxt = chg || (int_r && !(wr_csr && bus.wdata[tcs_pkg::CSR_INT])); // see R6
    flt_nxt = cable_power_overcurrent
      || (flt_r && !(wr_csr && bus.wdata[tcs_pkg::CSR_FLT])); // see R7
    int_n_nxt = !(int_nxt || flt_nxt); // see R5, see R13
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= tcs_pkg::ACC_NONE;
      cable_r <= 1'b0;
      att_r <= tcs_pkg::ATT_NONE;
      dir_r <= tcs_pkg::DIR_RST; // see R10
      int_r <= 1'b0;
      flt_r <= 1'b0;
      duty_r <= tcs_pkg::DUTY_RST;
      snk_r <= 1'b0;
      srst_r <= 1'b0;
      int_n_r <= 1'b1;
    end else begin
      acc_r <= acc_nxt;
      cable_r <= cable_nxt;
      att_r <= att_nxt;
      dir_r <= dir_nxt;
      int_r <= int_nxt;
      flt_r <= flt_nxt;
      duty_r <= duty_nxt;
      snk_r <= snk_nxt;
      srst_r <= srst_nxt;
      int_n_r <= int_n_nxt;
    end
  end

  // ----------------------------------------
  // read mux and outputs
  // ----------------------------------------
  always_comb begin
    if (bus.addr == tcs_pkg::OFS_CONN_STATUS) begin
      bus.rdata = {4'h0, acc_r, cable_r};
    end else if (bus.addr == tcs_pkg::OFS_CSR) begin
      bus.rdata = {att_r, dir_r, int_r, flt_r, duty_r, snk_r}; // see R10
    end else if (bus.addr == tcs_pkg::OFS_GEN_CTRL) begin
      bus.rdata = {4'h0, srst_r, 3'h0};
    end else begin
      bus.rdata = tcs_pkg::RD_ZERO;
    end
  end

  assign int_n = int_n_r;
  assign toggle_source_share = duty_r;
  assign sink_accessory_off = snk_r;
  assign soft_reset_out = srst_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_int_pin_status: assert property (@(posedge clk) disable iff (!nrst) // see R6
    int_r |-> !int_n)
    else $error("interrupt status set while pin is high");
  a_int_on_change: assert property (@(posedge clk) disable iff (!nrst) // see R5
    ($changed(att_r) || $changed(dir_r) || $changed(cable_r)) |-> int_r && !int_n)
    else $error("status change did not raise interrupt");
  a_fault_sets: assert property (@(posedge clk) disable iff (!nrst) // see R7
    cable_power_overcurrent |=> flt_r && !int_n)
    else $error("overcurrent did not set fault");
  a_int_sticky: assert property (@(posedge clk) disable iff (!nrst) // see R6
    (int_r && !(wr_csr && bus.wdata[tcs_pkg::CSR_INT])) |=> int_r)
    else $error("interrupt status dropped without clear");
  a_pin_release: assert property (@(posedge clk) disable iff (!nrst) // see R13
    (!int_r && !flt_r) |-> int_n)
    else $error("interrupt pin low with both flags clear");
  a_duty_write: assert property (@(posedge clk) disable iff (!nrst) // see R8
    wr_csr |=> toggle_source_share == $past(bus.wdata[2:1]))
    else $error("toggle share not written");
  a_srst_pulse: assert property (@(posedge clk) disable iff (!nrst) // see R11
    srst_r |=> !srst_r && dir_r == tcs_pkg::DIR_RST && att_r == tcs_pkg::ATT_NONE)
    else $error("soft reset not self-clearing or status not reset");
  a_acc_legal: assert property (@(posedge clk) disable iff (!nrst) // see R1
    acc_r == tcs_pkg::ACC_NONE || acc_r[2])
    else $error("reserved accessory code reported");
  a_snk_acc_off: assert property (@(posedge clk) disable iff (!nrst) // see R9
    (snk_r && !srst_r) |=> acc_r != tcs_pkg::ACC_DBG_SNK || !$past(snk_r))
    else $error("sink accessory shown while disabled");
endmodule : tcs_conn_status_csr

/* tcs_host_model.sv */
// partner model: two-wire bus host driving the clock and the open-drain data line
`timescale 1ns/10ps
module tcs_host_model (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  task automatic half();
    repeat (10) @(posedge clk);
  endtask : half
  // outside start and stop, data moves only well after the clock fall, never beside it
  task automatic start();
    repeat (3) @(posedge clk);
    sda_pull <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    repeat (3) @(posedge clk);
    sda_pull <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge clk);
    sda_pull <= ~b;
    half();
    scl <= 1'b1;
    half();
    r = sda_in;
    scl <= 1'b0;
  endtask : bit_io
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack_out);
  endtask : xfer
endmodule : tcs_host_model

/* tcs_tb.sv */
// testbench: status and control register bank reached over the two-wire port
`timescale 1ns/10ps
module testbench;
  logic clk, nrst, scl, pull, sda, oc, cab, ori, int_n, sda_oe, sao, sro;
  logic [2:0] acc;
  logic [1:0] att, tss;
  logic [7:0] got [0:15];
  logic [7:0] sr_cnt;
  logic nak_a;
  int mismatches, comparisons;
  // {acc, cable, attach, orient, pad, status byte, control byte}
  logic [23:0] rows [0:5] = '{24'h9C09D0, 24'hA60A70, 24'hD80D90, 24'hEA0EB0,
                              24'h420030, 24'h140150};
  assign sda = ~(pull | sda_oe);
  tcs_host_model host (.clk(clk), .sda_in(sda), .scl(scl), .sda_pull(pull));
  tcs_conn_status_csr uut (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .accessory_in(acc), .active_cable_in(cab), .attach_in(att),
    .orient_in(ori), .cable_power_overcurrent(oc), .int_n(int_n),
    .toggle_source_share(tss), .sink_accessory_off(sao), .soft_reset_out(sro));
  always #10 clk = ~clk;
  always @(posedge clk) if (sro === 1'b1) sr_cnt <= sr_cnt + 8'h01;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    host.start();
    host.xfer(8'h8E, 1'b1, q, a);
    chk({7'h00, a}, 8'h00);
    host.xfer(sub, 1'b1, q, a);
    chk({7'h00, a}, 8'h00);
    host.xfer(d, 1'b1, q, a);
    chk({7'h00, a}, 8'h00);
    host.stop();
  endtask : wr
  task automatic ptr(input logic [7:0] sub);
    logic [7:0] q;
    logic a;
    host.start();
    host.xfer(8'h8E, 1'b1, q, a);
    host.xfer(sub, 1'b1, q, a);
    host.stop();
  endtask : ptr
  // last byte is refused so the target lets go of the line
  task automatic rd(input int n);
    logic a;
    host.start();
    host.xfer(8'h8F, 1'b1, got[0], a);
    chk({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) host.xfer(8'hFF, i == n - 1, got[i], a);
    host.stop();
  endtask : rd
  task automatic irq(input logic [7:0] exp);
    repeat (3) @(posedge clk);
    chk({7'h00, int_n}, exp);
  endtask : irq
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    chk({int_n, sda_oe, tss, sao, sro, 2'h0}, 8'h80);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    oc = 1'b0;
    {acc, cab, att, ori} = 7'h01;
    sr_cnt = 8'h00;
    @(posedge clk);
    do_reset();
    rd(9);
    for (int i = 0; i < 9; i++) chk(got[i], 8'h00);
    rd(1);
    chk(got[0], 8'h20);
    for (int k = 0; k < 6; k++) begin
      {acc, cab, att, ori} <= rows[k][23:17];
      irq(8'h00);
      ptr(8'h08);
      rd(2);
      chk(got[0], rows[k][15:8]);
      chk(got[1], rows[k][7:0]);
      wr(8'h09, 8'h18);
      irq(8'h01);
    end
    for (int d = 0; d < 4; d++) begin
      wr(8'h09, {5'h00, d[1:0], 1'b1});
      chk({5'h00, tss, sao}, {5'h00, d[1:0], 1'b1});
    end
    acc <= 3'h7;
    ptr(8'h08);
    rd(2);
    chk(got[0], 8'h01);
    chk(got[1], 8'h57);
    wr(8'h09, 8'h1F);
    irq(8'h01);
    oc <= 1'b1;
    @(posedge clk);
    oc <= 1'b0;
    irq(8'h00);
    wr(8'h09, 8'h17);
    irq(8'h00);
    ptr(8'h09);
    rd(1);
    chk(got[0], 8'h4F);
    wr(8'h09, 8'h0F);
    irq(8'h01);
    acc <= 3'h0;
    wr(8'h0A, 8'h08);
    chk(sr_cnt, 8'h01);
    ptr(8'h08);
    rd(2);
    chk(got[0], 8'h01);
    chk(got[1], 8'h57);
    {acc, cab, att, ori} <= 7'h01;
    @(posedge clk);
    do_reset();
    ptr(8'h08);
    rd(2);
    chk(got[0], 8'h00);
    chk(got[1], 8'h20);
    // a foreign target address must be left unanswered and change nothing
    host.start();
    host.xfer(8'h90, 1'b1, got[2], nak_a);
    chk({7'h00, nak_a}, 8'h01);
    host.xfer(8'h09, 1'b1, got[2], nak_a);
    host.xfer(8'h06, 1'b1, got[2], nak_a);
    host.stop();
    chk({5'h00, tss, sao}, 8'h00);
    irq(8'h01);
    report_and_stop();
  end
endmodule : testbench
